// ===== mstx_map.svh
// offsets, field positions and reset values of the mac status block
`ifndef MSTX_MAP_SVH
`define MSTX_MAP_SVH

// register byte offsets on the apb bus
`define MSTX_ADDR_W        12
`define MSTX_OFF_STATUS    12'h000
`define MSTX_OFF_INT_STAT  12'h004
`define MSTX_OFF_INT_MASK  12'h008

// status word field positions
`define MSTX_IDLE_BIT      31
`define MSTX_CODE_MSB      23
`define MSTX_CODE_LSB      20
`define MSTX_CHAN_MSB      18
`define MSTX_CHAN_LSB      16

// transmit host error codes
`define MSTX_CODE_NONE     4'h0
`define MSTX_CODE_SOP      4'h1
`define MSTX_CODE_OWNER    4'h2
`define MSTX_CODE_NEXT     4'h3
`define MSTX_CODE_BUFPTR   4'h4
`define MSTX_CODE_BUFLEN   4'h5
`define MSTX_CODE_PKTLEN   4'h6

// interrupt bits and reset values
`define MSTX_INT_W         1
`define MSTX_INT_HOSTERR   0
`define MSTX_RST_WORD      32'h0000_0000
`define MSTX_RST_CHAN      3'h0
`define MSTX_RST_MASK      1'h0

`endif

// ===== mstx_pkg.sv
// types and shared decode for the mac status block
`include "mstx_map.svh"

package mstx_pkg;

  typedef logic [3:0] mstx_code_type;
  typedef logic [2:0] mstx_chan_type;
  typedef enum logic {st_idle, st_access} mstx_apb_state_type;

  // true for the codes that the transmit dma may report
  function automatic logic mstx_code_ok(input mstx_code_type c);
    mstx_code_ok = (c >= `MSTX_CODE_SOP) && (c <= `MSTX_CODE_PKTLEN);
  endfunction

endpackage

// ===== mstx_txerr.sv
// capture of the first transmit host error and its channel
`timescale 1ns/10ps
`include "mstx_map.svh"

module mstx_txerr
  import mstx_pkg::*;
#(
  parameter int N_TX_CHAN = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          err_valid,
  input  wire mstx_code_type err_code,
  input  wire mstx_chan_type err_chan,
  input  wire logic          rd_clear,
  output mstx_code_type      code_r,
  output mstx_chan_type      chan_r,
  output logic               locked_r,
  output logic               event_r
);

  logic take;

  // only the first legal error is taken; later ones find the block locked
  assign take = err_valid && !locked_r && mstx_code_ok(err_code)
                && (int'(err_chan) < N_TX_CHAN);

  // error code holds until hardware reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r   <= `MSTX_CODE_NONE;
      locked_r <= 1'b0;
    end else if (take) begin
      code_r   <= err_code;
      locked_r <= 1'b1;
    end
  end

  // channel loads on an error, clears on a host read; load wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_r <= `MSTX_RST_CHAN;
    end else if (take) begin
      chan_r <= err_chan;
    end else if (rd_clear) begin
      chan_r <= `MSTX_RST_CHAN;
    end
  end

  // one-cycle event toward the interrupt logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_r <= 1'b0;
    end else begin
      event_r <= take;
    end
  end

endmodule // mstx_txerr

// ===== mstx_irq.sv
// sticky interrupt status, mask and level interrupt output
`timescale 1ns/10ps

module mstx_irq #(
  parameter int N = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] w1c,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] mask_wdata,
  output logic      [N-1:0] stat_r,
  output logic      [N-1:0] mask_r,
  output logic              irq_r
);

  logic [N-1:0] stat_nxt;

  // set wins over a write-one-to-clear in the same cycle
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign stat_nxt[i] = set[i] | (stat_r[i] & ~w1c[i]);
  end

  // status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else if (mask_we) begin
      mask_r <= mask_wdata;
    end
  end

  // level output, high while an unmasked bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & (mask_we ? mask_wdata : mask_r));
    end
  end

endmodule // mstx_irq

// ===== mstx_status.sv
// apb status word of the mac: idle bit and transmit host error report
//
// Summary of operation
// - idle bit reads low in reset and follows the mac one clock after release
// - idle bit shows one while the mac is idle, zero otherwise
// - four-bit transmit host error code sits in bits 23 to 20
// - codes: 0 none, 1 missing start flag, 2 owner clear, 3 null next
// - codes: 4 null buffer, 5 zero length, 6 short buffers; 7 to f reserved
// - a zero packet length is not detected and leaves the code unchanged
// - after a host error the block stays locked until hardware reset
// - bits 18 to 16 give the channel number of the reported error
// - the channel field clears to zero when the host reads the word
`timescale 1ns/10ps
`include "mstx_map.svh"

module mstx_status
  import mstx_pkg::*;
#(
  parameter int N_TX_CHAN = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`MSTX_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     mac_idle,
  input  wire logic                     tx_err_valid,
  input  wire mstx_code_type            tx_err_code,
  input  wire mstx_chan_type            tx_err_chan,
  output logic                          host_error_interrupt_pending
);

  ////////////////////////////////////////////////////////////////////////
  // parameter check

  if (N_TX_CHAN < 1 || N_TX_CHAN > 8) begin : g_bad_chan
    $error("mstx_status: N_TX_CHAN must lie in 1..8");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int SEL_STATUS = 0;
  localparam int SEL_ISTAT  = 1;
  localparam int SEL_IMASK  = 2;

  mstx_apb_state_type   state_r;
  mstx_apb_state_type   state_nxt;
  logic                 idle_r;
  logic                 first_r;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 pready_r;
  logic                 pslverr_r;
  logic                 setup;
  logic                 done;
  logic [2:0]           sel;
  logic                 wr_istat;
  logic                 wr_imask;
  logic                 rd_status;
  mstx_code_type        code;
  mstx_chan_type        chan;
  logic                 locked;
  logic                 err_event;
  logic [`MSTX_INT_W-1:0] int_stat;
  logic [`MSTX_INT_W-1:0] int_mask;
  logic [`MSTX_INT_W-1:0] int_set;
  logic [`MSTX_INT_W-1:0] int_w1c;
  logic                 irq;
  logic [31:0]          status_word;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // one-hot select of the mapped registers, zero when unmapped
  function automatic logic [2:0] reg_sel(input logic [`MSTX_ADDR_W-1:0] a);
    logic [2:0] s;
    s = 3'h0;
    case (a)
      `MSTX_OFF_STATUS:   s[SEL_STATUS] = 1'b1;
      `MSTX_OFF_INT_STAT: s[SEL_ISTAT]  = 1'b1;
      `MSTX_OFF_INT_MASK: s[SEL_IMASK]  = 1'b1;
      default:            s = 3'h0;
    endcase
    reg_sel = s;
  endfunction

  assign sel   = reg_sel(paddr);
  assign setup = (state_r == st_idle) && psel && !penable;
  assign done  = (state_r == st_access) && psel && penable && pready_r;

  // writes and read side effects act only at the completing edge
  assign wr_istat  = done && pwrite && sel[SEL_ISTAT];
  assign wr_imask  = done && pwrite && sel[SEL_IMASK];
  assign rd_status = done && !pwrite && sel[SEL_STATUS];

  ////////////////////////////////////////////////////////////////////////
  // apb handshake

  // two-state walk: setup then one access cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_idle:   if (setup) state_nxt = st_access;
      st_access: if (done || !psel) state_nxt = st_idle;
      default:   state_nxt = st_idle;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ready is raised for exactly the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && (sel == 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // idle indication

  // low in reset, follows the mac from the first edge on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r  <= 1'b0;
      first_r <= 1'b0;
    end else begin
      idle_r  <= mac_idle;
      first_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit host error capture

  mstx_txerr #(
    .N_TX_CHAN (N_TX_CHAN)
  ) u_txerr (
    .pclk      (pclk),
    .presetn   (presetn),
    .err_valid (tx_err_valid),
    .err_code  (tx_err_code),
    .err_chan  (tx_err_chan),
    .rd_clear  (rd_status),
    .code_r    (code),
    .chan_r    (chan),
    .locked_r  (locked),
    .event_r   (err_event)
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt

  assign int_set[`MSTX_INT_HOSTERR] = err_event;
  assign int_w1c = wr_istat ? pwdata[`MSTX_INT_W-1:0] : '0;

  mstx_irq #(
    .N (`MSTX_INT_W)
  ) u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .set        (int_set),
    .w1c        (int_w1c),
    .mask_we    (wr_imask),
    .mask_wdata (pwdata[`MSTX_INT_W-1:0]),
    .stat_r     (int_stat),
    .mask_r     (int_mask),
    .irq_r      (irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data

  // status word; reserved bits are tied to zero
  always_comb begin
    status_word = `MSTX_RST_WORD;
    status_word[`MSTX_IDLE_BIT] = idle_r;
    status_word[`MSTX_CODE_MSB:`MSTX_CODE_LSB] = code;
    status_word[`MSTX_CHAN_MSB:`MSTX_CHAN_LSB] = chan;
  end

  // read mux, sampled in the setup cycle
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (sel)
        3'h1:    prdata_nxt = status_word;
        3'h2:    prdata_nxt = {{(32-`MSTX_INT_W){1'b0}}, int_stat};
        3'h4:    prdata_nxt = {{(32-`MSTX_INT_W){1'b0}}, int_mask};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data register, zero outside the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign host_error_interrupt_pending = irq;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic take_chk;
  assign take_chk = tx_err_valid && !locked && mstx_code_ok(tx_err_code)
                    && (int'(tx_err_chan) < N_TX_CHAN);

  a_idle_after_reset: assert property (
    $rose(first_r) |-> !$past(idle_r) && (idle_r == $past(mac_idle))
  ) else $error("idle bit wrong around reset release");

  a_idle_read_back: assert property (
    (setup && !pwrite && sel[SEL_STATUS])
      |=> prdata[`MSTX_IDLE_BIT] == $past(idle_r) && pready
  ) else $error("idle bit not returned on read");

  a_code_read_back: assert property (
    (setup && !pwrite && sel[SEL_STATUS])
      |=> prdata[`MSTX_CODE_MSB:`MSTX_CODE_LSB] == $past(code)
  ) else $error("error code not returned on read");

  a_code_capture: assert property (
    take_chk |=> (code == $past(tx_err_code)) && locked ##1 err_event == 1'b0
  ) else $error("error code not captured");

  a_code_in_range: assert property (
    (code == `MSTX_CODE_NONE) || mstx_code_ok(code)
  ) else $error("reserved error code stored");

  a_zero_len_ignored: assert property (
    (tx_err_valid && tx_err_code == `MSTX_CODE_NONE) |=> $stable(code)
  ) else $error("zero length changed the code");

  a_error_lock_hold: assert property (
    locked |=> locked && $stable(code)
  ) else $error("error state left without reset");

  a_irq_after_error: assert property (
    (take_chk && int_mask[`MSTX_INT_HOSTERR] && !wr_imask)
      |-> ##2 host_error_interrupt_pending
  ) else $error("host error interrupt not raised");

  a_chan_capture: assert property (
    take_chk |=> chan == $past(tx_err_chan)
  ) else $error("error channel not captured");

  a_chan_rd_clear: assert property (
    (rd_status && !take_chk) |=> chan == `MSTX_RST_CHAN
  ) else $error("channel not cleared by read");

  a_rsvd_read_zero: assert property (
    (setup && !pwrite && sel[SEL_STATUS])
      |=> prdata[30:24] == 7'h00 && !prdata[19] && prdata[15:0] == 16'h0000
  ) else $error("reserved status bits not zero");

  a_status_wr_ignored: assert property (
    (done && pwrite && sel[SEL_STATUS] && !take_chk && !rd_status)
      |=> $stable(code) && $stable(chan)
  ) else $error("status word changed by a write");

  a_idle_follows_mac: assert property (
    first_r |=> idle_r == $past(mac_idle)
  ) else $error("idle bit does not follow the mac");

  a_chan_read_value: assert property (
    (setup && !pwrite && sel[SEL_STATUS])
      |=> prdata[`MSTX_CHAN_MSB:`MSTX_CHAN_LSB] == $past(chan)
  ) else $error("error channel not returned on read");

  a_event_only_once: assert property (
    err_event |=> !err_event
  ) else $error("second host error event while locked");

endmodule // mstx_status

// ===== tb_mstx_status.sv
// self-checking testbench for the mac status word block
`timescale 1ns/10ps
`include "mstx_map.svh"

module tb_mstx_status
  import mstx_pkg::*;
;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [`MSTX_ADDR_W-1:0] paddr = '0;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    mac_idle = 1'b1;
  logic                    tx_err_valid = 1'b0;
  mstx_code_type           tx_err_code = 4'h0;
  mstx_chan_type           tx_err_chan = 3'h0;
  logic                    host_error_interrupt_pending;
  int                      bad_count = 0;
  int                      compares = 0;
  logic [31:0]             rd;
  logic                    er;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // clock, 100 ns period
  always #50 pclk = ~pclk;

  mstx_status #(.N_TX_CHAN(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_idle(mac_idle), .tx_err_valid(tx_err_valid), .tx_err_code(tx_err_code),
    .tx_err_chan(tx_err_chan), .host_error_interrupt_pending(host_error_interrupt_pending)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // verdict and compare helpers
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for pready; the watchdog bounds the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdo, output logic erro);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdo = prdata;
    erro = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset for ten cycles, outputs quiet meanwhile
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    chk({pready, pslverr, host_error_interrupt_pending}, 32'h0);
    chk(prdata, 32'h0);
    presetn <= 1'b1;
  endtask

  // error strobe of one cycle
  task automatic strobe(input mstx_code_type c, input mstx_chan_type ch);
    @(posedge pclk);
    tx_err_valid <= 1'b1;
    tx_err_code <= c;
    tx_err_chan <= ch;
    @(posedge pclk);
    tx_err_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_idle();
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8000_0000);
    mac_idle <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0000_0000);
    mac_idle <= 1'b1;
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8000_0000);
    $display("test idle done");
  endtask

  task automatic t_code(input int c);
    logic [31:0]   exp;
    mstx_chan_type ch;
    ch = 3'(c * 3);
    do_reset();
    strobe(4'h0, 3'h1);
    strobe(4'h7, 3'h2);
    strobe(4'hf, 3'h3);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8000_0000);
    chk(host_error_interrupt_pending, 1'b0);
    strobe(4'(c), ch);
    exp = 32'h8000_0000 | (32'(c) << `MSTX_CODE_LSB) | (32'(ch) << `MSTX_CHAN_LSB);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, exp);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8000_0000 | (32'(c) << `MSTX_CODE_LSB));
    strobe(4'h5, 3'h7);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8000_0000 | (32'(c) << `MSTX_CODE_LSB));
    apb(1'b0, `MSTX_OFF_INT_STAT, 32'h0, rd, er);
    chk(rd, 32'h0000_0001);
    $display("test code %0d done", c);
  endtask

  task automatic t_irq();
    chk(host_error_interrupt_pending, 1'b0);
    apb(1'b1, `MSTX_OFF_INT_MASK, 32'h1, rd, er);
    @(posedge pclk);
    chk(host_error_interrupt_pending, 1'b1);
    apb(1'b0, `MSTX_OFF_INT_MASK, 32'h0, rd, er);
    chk(rd, 32'h0000_0001);
    apb(1'b1, `MSTX_OFF_INT_STAT, 32'h1, rd, er);
    @(posedge pclk);
    chk(host_error_interrupt_pending, 1'b0);
    apb(1'b0, `MSTX_OFF_INT_STAT, 32'h0, rd, er);
    chk(rd, 32'h0000_0000);
    apb(1'b1, `MSTX_OFF_STATUS, 32'hffff_ffff, rd, er);
    chk(er, 1'b0);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8060_0000);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    do_reset();
    apb(1'b1, `MSTX_OFF_INT_MASK, 32'h1, rd, er);
    strobe(4'h2, 3'h5);
    chk(host_error_interrupt_pending, 1'b1);
    apb(1'b0, `MSTX_OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h8025_0000);
    $display("test irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    do_reset();
    t_idle();
    for (int c = 1; c <= 6; c++) begin
      t_code(c);
    end
    t_irq();
    print_verdict();
  end

  initial begin
    #(100 * 20000);
    bad_count++;
    print_verdict();
  end
endmodule // tb_mstx_status
